// ---- shared/dctim_map.vh ----
/*
  register map, field positions, reset values and encodings of the
  dual counter capture timer.
  assumes a 16-bit plain register port with word-sized registers.
*/
`ifndef DCTIM_MAP_VH
`define DCTIM_MAP_VH

// register offsets
`define DCT_OFF_CNT1      4'h0
`define DCT_OFF_CRA       4'h2
`define DCT_OFF_CRB       4'h4
`define DCT_OFF_CNT2      4'h6
`define DCT_OFF_CTRL      4'h8
`define DCT_OFF_ICTL      4'hA

// control register fields
`define DCT_CTRL_MODE_LO  0
`define DCT_CTRL_MODE_HI  1
`define DCT_CTRL_CS1_LO   2
`define DCT_CTRL_CS1_HI   4
`define DCT_CTRL_CS2_LO   5
`define DCT_CTRL_CS2_HI   7
`define DCT_CTRL_AEN      8
`define DCT_CTRL_BEN      9
`define DCT_CTRL_AOUT     10
`define DCT_CTRL_AEDGE    11
`define DCT_CTRL_BEDGE    12
`define DCT_CTRL_USED     13

// interrupt control fields
`define DCT_ICTL_AIEN     0
`define DCT_ICTL_BIEN     1
`define DCT_ICTL_CIEN     2
`define DCT_ICTL_DIEN     3
`define DCT_ICTL_APND     4
`define DCT_ICTL_BPND     5
`define DCT_ICTL_CPND     6
`define DCT_ICTL_DPND     7

// operating modes
`define DCT_MODE_PWM      2'h0
`define DCT_MODE_DUALCAP  2'h1
`define DCT_MODE_DUALTMR  2'h2
`define DCT_MODE_CAPTMR   2'h3

// clock selections
`define DCT_CS_STOP       3'h0
`define DCT_CS_SYS        3'h1
`define DCT_CS_PRESC      3'h2
`define DCT_CS_EXTEV      3'h3
`define DCT_CS_PACC       3'h4

// reset values
`define DCT_RST_WORD      16'h0000
`define DCT_RST_CTRL      13'h0000
`define DCT_RST_ICTL      8'h00
`define DCT_ALL_ONES      16'hFFFF

// prescaler divide ratio, system clocks per prescaled tick
`define DCT_PRESC_DIV     8'h20

// system interrupt line numbers per unit
`define DCT_U1_IRQ_I      4'hD
`define DCT_U1_IRQ_II     4'hC
`define DCT_U2_IRQ_I      4'hB
`define DCT_U2_IRQ_II     4'hA

`endif

// ---- core/dctim_clkdiv.v ----
/*
  prescaler: one-cycle enable pulse every DCT_PRESC_DIV system clocks.
  assumes the system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dctim_map.vh"

module dctim_clkdiv
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // prescaled tick
  output reg        tick_ff
);

  reg  [7:0] div_ff;
  wire       wrap;

  assign wrap = (div_ff == (`DCT_PRESC_DIV - 8'h01));

  always @(posedge clk)
  begin
    if (rst)
    begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= wrap ? 8'h00 : div_ff + 8'h01;
      tick_ff <= wrap;
    end
  end

endmodule
`default_nettype wire

// ---- core/dctim_top.v ----
/*
  two-counter timer unit: pwm, dual capture, dual timer and single
  capture plus timer modes, with four interrupt sources on two lines.
  assumes pins are asynchronous to CLK and a plain register port.
*/
// Contract
// R1: mode 4 primary counter counts down, reloads from reg A on underflow.
// R2: mode 4 with pin A enable toggles pin A each primary underflow.
// R3: mode 4 secondary counts down; pin B edge copies it to reg B.
// R4: capture preset copies counter first, then loads all ones.
// R5: capture pulses last at least one system clock.
// R6: mode 4 pin B capture and secondary underflow raise B and D events.
// R7: mode 2/4 external or accumulate clocking stops that counter.
// R8: software keeps the secondary counter enabled in mode 4.
// R9: four sources; A, B, C drive first line, D the second.
// R10: first unit lines are system interrupts 13 and 12.
// R11: second unit lines are system interrupts 11 and 10.
// R12: A set by reload from reg A (1,3,4), capture on A (2).
// R13: B set by reload from reg B (1), pin B capture (2,4).
// R14: C only mode 2 primary underflow; D secondary underflow or reload.
// R15: pin A toggles per underflow from output state bit level.
// R16: software presets the output state bit before enabling the clock.
// R17: pin B enable presets capturing counter to all ones.
// R18: modes 1 and 3 pin B is event or accumulate input.
// R19: output state bit tracks pin A; software write wins.
// R20: interrupt control is an 8-bit read/write register.
// R21: each line is high while an enabled mapped flag is pending.
`timescale 1ns/1ps
`default_nettype none
`include "dctim_map.vh"

module dctim_top
#(
  parameter UNIT = 1
)
(
  // clock and reset
  input  wire        CLK,
  input  wire        SYS_RST,
  // register port
  input  wire [3:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // timer pins
  input  wire        PIN_A_IN,
  output reg         PIN_A_OUT,
  output reg         PIN_A_OE_N,
  input  wire        PIN_B_IN,
  // system interrupts
  output reg         IRQ_I,
  output reg         IRQ_II,
  output reg  [3:0]  IRQ_I_LINE,
  output reg  [3:0]  IRQ_II_LINE
);

  reg  [15:0] cnt1_ff;
  reg  [15:0] cnt2_ff;
  reg  [15:0] cra_ff;
  reg  [15:0] crb_ff;
  reg  [12:0] ctrl_ff;
  reg  [7:0]  ictl_ff;
  reg         sel_b_ff;
  reg  [1:0]  sync1_ff;
  reg  [1:0]  sync2_ff;
  reg  [1:0]  prev_ff;
  reg  [15:0] nxt_cnt1;
  reg  [15:0] nxt_cnt2;
  reg  [15:0] nxt_cra;
  reg  [15:0] nxt_crb;
  reg  [12:0] nxt_ctrl;
  reg  [7:0]  nxt_ictl;
  reg         nxt_sel_b;
  reg  [3:0]  set_pnd;
  wire        presc_tick;
  wire [1:0]  mode;
  wire [2:0]  cs1;
  wire [2:0]  cs2;
  wire        a_en;
  wire        b_en;
  wire        a_out;
  wire        edge_a;
  wire        edge_b;
  wire        capt_mode;
  wire        tick1;
  wire        tick2;
  wire        unf1;
  wire        unf2;
  wire        wr_cnt1;
  wire        wr_cnt2;
  wire        wr_cra;
  wire        wr_crb;
  wire        wr_ctrl;
  wire        wr_ictl;

  dctim_clkdiv u_clkdiv
  (
    .clk     (CLK),
    .rst     (SYS_RST),
    .tick_ff (presc_tick)
  );

  // pins are asynchronous: two flops, then a third for edge history
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_sync
      // no reset: the chain fills with the idle pin level while reset
      // is held (three clocks), so release never shows a false edge
      always @(posedge CLK)
      begin
        sync1_ff[g] <= (g == 0) ? PIN_A_IN : PIN_B_IN;
        sync2_ff[g] <= sync1_ff[g];
        prev_ff[g]  <= sync2_ff[g];
      end
    end
  endgenerate

  assign mode  = ctrl_ff[`DCT_CTRL_MODE_HI:`DCT_CTRL_MODE_LO];
  assign cs1   = ctrl_ff[`DCT_CTRL_CS1_HI:`DCT_CTRL_CS1_LO];
  assign cs2   = ctrl_ff[`DCT_CTRL_CS2_HI:`DCT_CTRL_CS2_LO];
  assign a_en  = ctrl_ff[`DCT_CTRL_AEN];
  assign b_en  = ctrl_ff[`DCT_CTRL_BEN];
  assign a_out = ctrl_ff[`DCT_CTRL_AOUT];

  // capture edge polarity: 1 senses rising, 0 falling
  assign edge_a = ctrl_ff[`DCT_CTRL_AEDGE] ? (sync2_ff[0] & ~prev_ff[0])
                                           : (~sync2_ff[0] & prev_ff[0]);
  assign edge_b = ctrl_ff[`DCT_CTRL_BEDGE] ? (sync2_ff[1] & ~prev_ff[1])
                                           : (~sync2_ff[1] & prev_ff[1]);

  assign capt_mode = (mode == `DCT_MODE_DUALCAP) ||
                     (mode == `DCT_MODE_CAPTMR);

  // counter clock decode, shared by both counters
  function clk_tick;
    input [2:0] sel;
    input       capt;
    input       presc;
    input       ev_b;
    input       lvl_b;
    begin
      case (sel)
        `DCT_CS_SYS:   clk_tick = 1'b1;
        `DCT_CS_PRESC: clk_tick = presc;
        // R7 pin b is a capture input, so event clocks stall
        `DCT_CS_EXTEV: clk_tick = ~capt & ev_b;
        `DCT_CS_PACC:  clk_tick = ~capt & lvl_b;
        default:       clk_tick = 1'b0;
      endcase
    end
  endfunction

  // R18 event input counts rising edges, accumulate gates on high level
  assign tick1 = clk_tick(cs1, capt_mode, presc_tick,
                          sync2_ff[1] & ~prev_ff[1], sync2_ff[1]);
  assign tick2 = clk_tick(cs2, capt_mode, presc_tick,
                          sync2_ff[1] & ~prev_ff[1], sync2_ff[1]);
  assign unf1  = tick1 & (cnt1_ff == `DCT_RST_WORD);
  assign unf2  = tick2 & (cnt2_ff == `DCT_RST_WORD);

  assign wr_cnt1 = WR & (ADDR == `DCT_OFF_CNT1);
  assign wr_cnt2 = WR & (ADDR == `DCT_OFF_CNT2);
  assign wr_cra  = WR & (ADDR == `DCT_OFF_CRA);
  assign wr_crb  = WR & (ADDR == `DCT_OFF_CRB);
  assign wr_ctrl = WR & (ADDR == `DCT_OFF_CTRL);
  assign wr_ictl = WR & (ADDR == `DCT_OFF_ICTL);

  always @*
  begin
    nxt_cnt1  = tick1 ? cnt1_ff - 16'h0001 : cnt1_ff;
    nxt_cnt2  = tick2 ? cnt2_ff - 16'h0001 : cnt2_ff;
    nxt_cra   = cra_ff;
    nxt_crb   = crb_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_ictl  = ictl_ff;
    nxt_sel_b = sel_b_ff;
    set_pnd   = 4'h0;
    case (mode)
      `DCT_MODE_PWM:
      begin
        if (unf1)
        begin
          // alternate reload, A first after every restart
          nxt_cnt1  = sel_b_ff ? crb_ff : cra_ff;
          nxt_sel_b = ~sel_b_ff;
          set_pnd[0] = ~sel_b_ff;
          // R13 reload from reg B
          set_pnd[1] = sel_b_ff;
        end
        // R14 secondary underflow
        set_pnd[3] = unf2;
      end
      `DCT_MODE_DUALCAP:
      begin
        // R14 primary wraps through all ones, flag C
        set_pnd[2] = unf1;
        set_pnd[3] = unf2;
        if (edge_a)
        begin
          // R12 capture on pin A
          nxt_cra    = cnt1_ff;
          set_pnd[0] = 1'b1;
        end
        if (edge_b)
        begin
          // R13 capture on pin B
          nxt_crb    = cnt1_ff;
          set_pnd[1] = 1'b1;
        end
        // R17 preset the primary after the copy
        if ((edge_a & a_en) | (edge_b & b_en))
          nxt_cnt1 = `DCT_ALL_ONES;
      end
      `DCT_MODE_DUALTMR:
      begin
        if (unf1)
          nxt_cnt1 = cra_ff;
        set_pnd[0] = unf1;
        // R14 secondary reload from reg B sets D
        if (unf2)
          nxt_cnt2 = crb_ff;
        set_pnd[3] = unf2;
      end
      default:
      begin
        // R1 reload from reg A and keep counting down
        if (unf1)
          nxt_cnt1 = cra_ff;
        // R12 reload from reg A
        set_pnd[0] = unf1;
        // R6 secondary underflow event
        set_pnd[3] = unf2;
        if (edge_b)
        begin
          // R3 capture secondary on pin B edge
          nxt_crb    = cnt2_ff;
          set_pnd[1] = 1'b1;
          // R4 copy taken above, then preset
          if (b_en)
            nxt_cnt2 = `DCT_ALL_ONES;
        end
      end
    endcase
    // stopped primary clock restarts the alternation at reg A
    if (cs1 == `DCT_CS_STOP)
      nxt_sel_b = 1'b0;
    // R15 toggle from the output state bit, never in dual capture mode
    if (unf1 & a_en & (mode != `DCT_MODE_DUALCAP))
      nxt_ctrl[`DCT_CTRL_AOUT] = ~a_out;
    if (wr_cnt1)
      nxt_cnt1 = WDATA;
    if (wr_cnt2)
      nxt_cnt2 = WDATA;
    if (wr_cra)
      nxt_cra = WDATA;
    if (wr_crb)
      nxt_crb = WDATA;
    // R19 software write wins over the hardware toggle
    if (wr_ctrl)
    begin
      nxt_ctrl = WDATA[`DCT_CTRL_USED-1:0];
      // mode change restarts the alternation at reg A
      if (WDATA[`DCT_CTRL_MODE_HI:`DCT_CTRL_MODE_LO] != mode)
        nxt_sel_b = 1'b0;
    end
    // R20 byte-wide read/write control
    if (wr_ictl)
      nxt_ictl = WDATA[7:0];
    // R9 hardware set wins over a software clear
    nxt_ictl[`DCT_ICTL_DPND:`DCT_ICTL_APND] =
      nxt_ictl[`DCT_ICTL_DPND:`DCT_ICTL_APND] | set_pnd;
  end

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cnt1_ff     <= `DCT_RST_WORD;
      cnt2_ff     <= `DCT_RST_WORD;
      cra_ff      <= `DCT_RST_WORD;
      crb_ff      <= `DCT_RST_WORD;
      ctrl_ff     <= `DCT_RST_CTRL;
      ictl_ff     <= `DCT_RST_ICTL;
      sel_b_ff    <= 1'b0;
      RDATA       <= `DCT_RST_WORD;
      PIN_A_OUT   <= 1'b0;
      PIN_A_OE_N  <= 1'b1;
      IRQ_I       <= 1'b0;
      IRQ_II      <= 1'b0;
      IRQ_I_LINE  <= 4'h0;
      IRQ_II_LINE <= 4'h0;
    end
    else
    begin
      cnt1_ff   <= nxt_cnt1;
      cnt2_ff   <= nxt_cnt2;
      cra_ff    <= nxt_cra;
      crb_ff    <= nxt_crb;
      ctrl_ff   <= nxt_ctrl;
      ictl_ff   <= nxt_ictl;
      sel_b_ff  <= nxt_sel_b;
      PIN_A_OUT <= nxt_ctrl[`DCT_CTRL_AOUT];
      // R2 pin A driven as pwm output when enabled, outside dual capture mode
      PIN_A_OE_N <= ~(nxt_ctrl[`DCT_CTRL_AEN] &
                      (nxt_ctrl[`DCT_CTRL_MODE_HI:`DCT_CTRL_MODE_LO] !=
                       `DCT_MODE_DUALCAP));
      // R21 enabled pending flags drive the lines
      IRQ_I  <= |(nxt_ictl[`DCT_ICTL_CPND:`DCT_ICTL_APND] &
                  nxt_ictl[`DCT_ICTL_CIEN:`DCT_ICTL_AIEN]);
      IRQ_II <= nxt_ictl[`DCT_ICTL_DPND] & nxt_ictl[`DCT_ICTL_DIEN];
      // R10 first unit line numbers
      // R11 second unit line numbers
      IRQ_I_LINE  <= (UNIT == 2) ? `DCT_U2_IRQ_I : `DCT_U1_IRQ_I;
      IRQ_II_LINE <= (UNIT == 2) ? `DCT_U2_IRQ_II : `DCT_U1_IRQ_II;
      // unmapped addresses read zero
      if (RD)
      begin
        case (ADDR)
          `DCT_OFF_CNT1: RDATA <= cnt1_ff;
          `DCT_OFF_CNT2: RDATA <= cnt2_ff;
          `DCT_OFF_CRA:  RDATA <= cra_ff;
          `DCT_OFF_CRB:  RDATA <= crb_ff;
          `DCT_OFF_CTRL: RDATA <= {3'h0, ctrl_ff};
          `DCT_OFF_ICTL: RDATA <= {8'h00, ictl_ff};
          default:       RDATA <= `DCT_RST_WORD;
        endcase
      end
      else
        RDATA <= `DCT_RST_WORD;
    end
  end

endmodule
`default_nettype wire

// ---- dv/dctim_pins.sv ----
/*
  model of the two timer pins outside the unit.
  assumes pin a has a pull-up and pin b pulses when the bench asks.
*/
`timescale 1ns/1ps
`default_nettype none
module dctim_pins (
  // timing
  input  wire logic       clk,
  // requests from the bench
  input  wire logic       b_go,
  input  wire logic [2:0] b_wid,
  // unit side of pin a
  input  wire logic       a_out,
  input  wire logic       a_oe_n,
  // pin levels
  output wire logic       pin_a,
  output var  logic       pin_b
);
  // pull-up holds pin a high whenever the unit lets go of it
  assign pin_a = a_oe_n ? 1'b1 : a_out;
  initial pin_b = 1'b0;
  always @(posedge clk)
  begin
    if (b_go)
    begin
      #3 pin_b = 1'b1;
      repeat (b_wid) @(posedge clk);
      #3 pin_b = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- dv/dctim_top_assertions.sv ----
/*
  port assertions of the timer unit, bound to its top module.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dctim_map.vh"
module dctim_chk #(parameter UNIT = 1) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // register port
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  // pins
  input wire logic        PIN_A_IN,
  input wire logic        PIN_A_OUT,
  input wire logic        PIN_A_OE_N,
  input wire logic        PIN_B_IN,
  // interrupts
  input wire logic        IRQ_I,
  input wire logic        IRQ_II,
  input wire logic [3:0]  IRQ_I_LINE,
  input wire logic [3:0]  IRQ_II_LINE
);
  logic [12:0] ctrl_ff;
  logic [3:0]  ien_ff;
  logic [14:0] ctrl_rd;
  // shadows of software writes; hardware alters only bit 10 and pendings
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_ff <= 13'h0000;
      ien_ff  <= 4'h0;
    end
    else if (WR && ADDR == 4'h8)
      ctrl_ff <= WDATA[12:0];
    else if (WR && ADDR == 4'hA)
      ien_ff <= WDATA[3:0];
  end
  assign ctrl_rd = {3'b000, ctrl_ff[12:11], ctrl_ff[9:0]};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_rdata_idle:
    assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside answer");
  a_ictl_read:
    assert property (RD && ADDR == 4'hA |=> RDATA[3:0] == $past(ien_ff)
      && RDATA[15:8] == 8'h00) else $error("interrupt enables misread");
  a_ctrl_read:
    assert property (RD && ADDR == 4'h8 |=> {RDATA[15:11], RDATA[9:0]}
      == $past(ctrl_rd)) else $error("control misread");
  a_aout_write:
    assert property (WR && ADDR == 4'h8 |=> PIN_A_OUT == ctrl_ff[10])
    else $error("pin a level ignores software write");
  a_oe_drive:
    assert property ($stable(ctrl_ff) |-> PIN_A_OE_N ==
      !(ctrl_ff[8] && ctrl_ff[1:0] != 2'h1)) else $error("pin a enable");
  a_hold_stopped:
    assert property (ctrl_ff[4:2] == 3'h0 && $stable(ctrl_ff) && !$past(WR)
      |-> $stable(PIN_A_OUT)) else $error("pin a moved while stopped");
  a_irq_gate:
    assert property (ien_ff[2:0] == 3'h0 |-> !IRQ_I)
    else $error("first line high with sources off");
  a_irq_set:
    assert property (WR && ADDR == 4'hA && WDATA[7] && WDATA[3] |=> IRQ_II)
    else $error("second line missing for pending d");
  a_line_one:
    assert property (!$past(SYS_RST) |-> IRQ_I_LINE == (UNIT == 1 ?
      `DCT_U1_IRQ_I : `DCT_U2_IRQ_I)) else $error("first line number");
  a_line_two:
    assert property (!$past(SYS_RST) |-> IRQ_II_LINE == (UNIT == 1 ?
      `DCT_U1_IRQ_II : `DCT_U2_IRQ_II)) else $error("second line number");
  cover property ($rose(IRQ_I));
  cover property ($rose(IRQ_II));
  cover property ($changed(PIN_A_OUT) && !$past(WR));
  cover property (RD && ADDR == 4'hA);
endmodule
bind dctim_top dctim_chk #(.UNIT(UNIT)) i_dctim_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .PIN_A_IN(PIN_A_IN), .PIN_A_OUT(PIN_A_OUT),
  .PIN_A_OE_N(PIN_A_OE_N), .PIN_B_IN(PIN_B_IN), .IRQ_I(IRQ_I),
  .IRQ_II(IRQ_II), .IRQ_I_LINE(IRQ_I_LINE), .IRQ_II_LINE(IRQ_II_LINE));
`default_nettype wire

// ---- dv/test_dual_counter_capture_timer_irq.sv ----
/*
  self-checking bench for the timer unit with its pin model.
  assumes the checker is bound to the unit by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dctim_map.vh"
module test_dual_counter_capture_timer_irq;
  logic        CLK, SYS_RST, WR, RD, b_go, rd_d;
  logic [3:0]  ADDR, IRQ_I_LINE, IRQ_II_LINE;
  logic [15:0] WDATA, RDATA;
  logic        PIN_A_IN, PIN_A_OUT, PIN_A_OE_N, PIN_B_IN, IRQ_I, IRQ_II;
  logic [2:0]  b_wid;
  logic [15:0] cap;
  logic [31:0] seed;
  logic [35:0] nt;
  logic [35:0] notes[$];
  int          n_fail, checks, n, i;
  dctim_top #(.UNIT(1)) i_dctim_top (
    .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PIN_A_IN(PIN_A_IN), .PIN_A_OUT(PIN_A_OUT),
    .PIN_A_OE_N(PIN_A_OE_N), .PIN_B_IN(PIN_B_IN), .IRQ_I(IRQ_I),
    .IRQ_II(IRQ_II), .IRQ_I_LINE(IRQ_I_LINE), .IRQ_II_LINE(IRQ_II_LINE));
  dctim_pins i_dctim_pins (.clk(CLK), .b_go(b_go), .b_wid(b_wid),
    .a_out(PIN_A_OUT), .a_oe_n(PIN_A_OE_N), .pin_a(PIN_A_IN),
    .pin_b(PIN_B_IN));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    RD <= 1'b0;
    WR <= 1'b1;
    @(posedge CLK);
  endtask
  // expected value is masked already; the monitor masks the answer
  task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
    notes.push_back({a, m, e});
    ADDR <= a;
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
  endtask
  task automatic cyc(input int c);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (c) @(posedge CLK);
  endtask
  task automatic tog(output int c);
    logic l;
    l = PIN_A_OUT;
    c = 0;
    while (PIN_A_OUT === l && c < 300)
    begin
      @(posedge CLK);
      c++;
    end
  endtask
  // long gap lets the pulse, the synchroniser and the capture finish
  task automatic pulse(input logic [2:0] w);
    b_wid <= w;
    b_go <= 1'b1;
    @(posedge CLK);
    b_go <= 1'b0;
    repeat (14) @(posedge CLK);
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    if (rd_d)
    begin
      nt = notes.pop_front();
      chk($sformatf("reg %h", nt[35:32]), RDATA & nt[31:16], nt[15:0]);
    end
    rd_d <= RD;
  end
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial
  begin
    repeat (5000) @(posedge CLK);
    n_fail++;
    give_verdict;
  end
  initial
  begin
    {SYS_RST, WR, RD, b_go, rd_d} = 5'b10000;
    ADDR = 4'h0;
    WDATA = 16'h0000;
    b_wid = 3'h1;
    seed = 32'h0001_04F9;
    n_fail = 0;
    checks = 0;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    for (i = 0; i < 16; i += 2)
      rd(i[3:0], 16'h0000, 16'hFFFF);
    wr(4'hE, 16'hFFFF);
    rd(4'h8, 16'h0000, 16'hFFFF);
    cyc(1);
    chk("line1", 16'(IRQ_I_LINE), 16'(`DCT_U1_IRQ_I));
    chk("line2", 16'(IRQ_II_LINE), 16'(`DCT_U1_IRQ_II));
    for (i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(4'hA, seed[15:0]);
      rd(4'hA, {8'h00, seed[7:0]}, 16'hFFFF);
      cyc(1);
      chk("irq1", 16'(IRQ_I), 16'(|(seed[6:4] & seed[2:0])));
      chk("irq2", 16'(IRQ_II), 16'(seed[7] & seed[3]));
    end
    seed = lfsr(seed);
    n = 2 + seed[3:0];
    wr(4'h2, 16'(n));
    wr(4'h0, 16'(n));
    wr(4'hA, 16'h0000);
    // start level set before the clock
    wr(4'h8, 16'h0523);
    wr(4'h8, 16'h0527);
    cyc(1);
    chk("pin_a", 16'(PIN_A_OUT), 16'h0001);
    chk("oe_n", 16'(PIN_A_OE_N), 16'h0000);
    tog(i);
    tog(i);
    chk("half1", 16'(i), 16'(n + 1));
    tog(i);
    chk("half2", 16'(i), 16'(n + 1));
    rd(4'hA, 16'h0010, 16'h0070);
    wr(4'h8, 16'h0123);
    rd(4'h8, 16'h0123, 16'hFFFF);
    wr(4'hA, 16'h0008);
    wr(4'h6, 16'h0003);
    cyc(1);
    rd(4'hA, 16'h0008, 16'h00FF);
    cyc(6);
    rd(4'hA, 16'h0088, 16'h00FF);
    cyc(1);
    chk("irq2", 16'(IRQ_II), 16'h0001);
    // capture: primary held by its pin clock, secondary kept running
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      cap = {1'b1, seed[14:0]};
      // edge is acted on 5 clocks after the counter write, plus width for a falling edge
      n = i[1] ? 5 : 6 + seed[1:0];
      wr(4'h8, {3'h0, i[1], 2'h0, i[0], 9'h033});
      wr(4'h0, seed[31:16]);
      wr(4'h6, cap);
      wr(4'hA, 16'h0002);
      cyc(1);
      pulse(3'(1 + seed[1:0]));
      rd(4'h4, cap - 16'(n), 16'hFFFF);
      rd(4'h6, i[0] ? 16'hFFEE + 16'(n) : cap - 16'h0012, 16'hFFFF);
      rd(4'h0, seed[31:16], 16'hFFFF);
      rd(4'hA, 16'h0022, 16'h00FF);
      cyc(1);
      chk("irq1", 16'(IRQ_I), 16'h0001);
    end
    // dual timer: pin b edges clock the secondary, its enable ignored
    wr(4'h8, 16'h0262);
    wr(4'h6, 16'h0005);
    cyc(1);
    pulse(3'h1);
    pulse(3'h3);
    rd(4'h6, 16'h0003, 16'hFFFF);
    // dual timer: secondary underflow reloads from reg B
    wr(4'h4, 16'h0009);
    wr(4'h6, 16'h0000);
    wr(4'hA, 16'h0000);
    cyc(1);
    pulse(3'h2);
    rd(4'h6, 16'h0009, 16'hFFFF);
    rd(4'hA, 16'h0080, 16'h00FF);
    // dual capture: pin B copies the primary, preset follows the copy
    seed = lfsr(seed);
    wr(4'h8, 16'h0201);
    wr(4'h0, seed[15:0]);
    wr(4'hA, 16'h0006);
    cyc(1);
    pulse(3'h2);
    rd(4'h4, seed[15:0], 16'hFFFF);
    rd(4'h0, 16'hFFFF, 16'hFFFF);
    rd(4'hA, 16'h0026, 16'h00FF);
    wr(4'h0, 16'h0002);
    wr(4'h8, 16'h0205);
    cyc(4);
    rd(4'hA, 16'h0066, 16'h00FF);
    // pwm: reloads alternate, reg A first after the stop
    wr(4'h8, 16'h0100);
    wr(4'h2, 16'h0003);
    wr(4'h4, 16'h0006);
    wr(4'h0, 16'h0000);
    wr(4'hA, 16'h0000);
    wr(4'h8, 16'h0104);
    cyc(1);
    tog(i);
    tog(i);
    chk("half_a", 16'(i), 16'h0004);
    tog(i);
    chk("half_b", 16'(i), 16'h0007);
    rd(4'hA, 16'h0030, 16'h00FF);
    cyc(2);
    give_verdict;
  end
endmodule
`default_nettype wire
